// ### rtl/ptc_pkg.sv
package ptc_pkg;

  // Link level command codes
  localparam logic [7:0] LINK_REQ_WAKE = 8'h05;
  localparam logic [7:0] LINK_ATTRIB   = 8'h1d;
  localparam logic [7:0] LINK_HALT     = 8'h50;

  // Instruction codes
  localparam logic [7:0] INS_SELECT = 8'ha4;
  localparam logic [7:0] INS_READ   = 8'hb0;
  localparam logic [7:0] INS_WRITE  = 8'hd6;
  localparam logic [7:0] CLA_OK     = 8'h00;

  // Status words
  localparam logic [15:0] SW_OK      = 16'h9000;
  localparam logic [15:0] SW_LEN_ERR = 16'h6700;
  localparam logic [15:0] SW_P12_ERR = 16'h6a86;
  localparam logic [15:0] SW_INS_ERR = 16'h6d00;
  localparam logic [15:0] SW_CLA_ERR = 16'h6e00;
  localparam logic [15:0] SW_ACC_ERR = 16'h6f00;

  // Field positions
  localparam int PRM_WAKE_BIT = 3;
  localparam int P1_ERR_BIT   = 7;
  localparam int P1_MODE_LSB  = 4;
  localparam int ENC_UNIT_LSB = 4;   // 16 byte unit

  // Mode field codes
  localparam logic [2:0] MODE_PLAIN = 3'h0;
  localparam logic [2:0] MODE_PRIV  = 3'h2;
  localparam logic [2:0] MODE_FAM   = 3'h3;

  // APB map
  localparam logic [11:0] OFS_AFI    = 12'h000;
  localparam logic [11:0] OFS_RO_LIM = 12'h004;
  localparam logic [11:0] OFS_ENC_LO = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_COUNT  = 12'h010;

  // Reset values
  localparam logic [7:0]  AFI_RST    = 8'h00;
  localparam logic [12:0] RO_LIM_RST = 13'h0000;
  localparam logic [12:0] ENC_LO_RST = 13'h1000;

  // Block types delivered by the frame layer
  typedef enum logic [2:0] {
    PTC_BLK_LINK  = 3'h0,
    PTC_BLK_IBLK  = 3'h1,
    PTC_BLK_ACK   = 3'h2,
    PTC_BLK_NAK   = 3'h3,
    PTC_BLK_DESEL = 3'h4
  } ptc_blk_e;

  // Answer kinds
  typedef enum logic [2:0] {
    PTC_RSP_ATQB   = 3'h0,
    PTC_RSP_ATTRIB = 3'h1,
    PTC_RSP_APDU   = 3'h2,
    PTC_RSP_ACK    = 3'h3,
    PTC_RSP_DESEL  = 3'h4
  } ptc_rsp_e;

  // Protocol states, one-hot
  typedef enum logic [3:0] {
    PTC_ST_IDLE   = 4'h1,
    PTC_ST_READY  = 4'h2,
    PTC_ST_ACTIVE = 4'h4,
    PTC_ST_HALT   = 4'h8
  } ptc_state_e;

  typedef struct packed {
    ptc_blk_e    blk;
    logic        chain;
    logic [7:0]  code;
    logic [7:0]  afi;
    logic [7:0]  param;
    logic [7:0]  cla;
    logic [7:0]  ins;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [8:0]  lc;
    logic [8:0]  le;
  } ptc_cmd_s;

  typedef struct packed {
    ptc_rsp_e    kind;
    logic [15:0] sw;
  } ptc_rsp_s;

endpackage

// ### rtl/ptc_core.sv
`timescale 1ns/10ps
// Functional notes
// - Out-of-range read or write length fields answer 6700
// - Encrypted lengths not multiple of sixteen: 6700
// - Encrypted address not sixteen aligned: 6A86
// - Unknown instruction answers 6D00
// - Nonzero class byte answers 6E00
// - Write into read-only area answers 6F00
// - Plaintext access to encrypted area: 6F00
// - Selection may answer 6700 for some parameters
// - Code 05 decoded as identification request
// - Code 1D enters command processing state
// - Code 50 enters halt state
// - Selection accepted, performs nothing
// - Instruction B0 decoded as read
// - Instruction D6 decoded as write
// - Request form answered from idle or ready, not from halt
// - Wake-up form answered from halt, idle or ready
// - Parameter bits 7-5 ignored
// - Single slot, immediate answer always
// - Family identifier wildcard and nibble matching
// - Chaining, ack/nak and deselect blocks supported
module ptc_core #(
  parameter int NVM_BYTES = 4096,
  parameter int MAX_LEN   = 256
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cmd_valid,
  input  wire ptc_pkg::ptc_cmd_s cmd,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output ptc_pkg::ptc_rsp_s      rsp
);

  // Elaboration checks
  generate
    if (NVM_BYTES < 16 || NVM_BYTES > 4096) begin : g_bad_nvm
      $error("NVM_BYTES must lie in 16..4096");
    end
    if (MAX_LEN < 16 || MAX_LEN > 256) begin : g_bad_len
      $error("MAX_LEN must lie in 16..256");
    end
  endgenerate

  localparam logic [12:0] NVM_LIM = 13'(NVM_BYTES);
  localparam logic [8:0]  LEN_LIM = 9'(MAX_LEN);

  // Family identifier match, wildcard and nibble forms
  function automatic logic afi_match(input logic [7:0] req, input logic [7:0] own);
    logic m;
    m = 1'b0;
    if (req == 8'h00) begin
      m = 1'b1;
    end else if (req[3:0] == 4'h0) begin
      m = (req[7:4] == own[7:4]);
    end else if (req[7:4] == 4'h0) begin
      m = (req[3:0] == own[3:0]);
    end else begin
      m = (req == own);
    end
    return m;
  endfunction

  // Length range check shared by lc and le
  function automatic logic len_bad(input logic [8:0] len, input logic enc);
    logic b;
    b = (len == 9'h000) || (len > LEN_LIM);
    if (enc && (len[ptc_pkg::ENC_UNIT_LSB-1:0] != '0)) begin
      b = 1'b1;
    end
    return b;
  endfunction

  // Registers
  ptc_pkg::ptc_state_e state_r, state_nxt;
  logic [7:0]          afi_r;
  logic [12:0]         ro_lim_r;
  logic [12:0]         enc_lo_r;
  logic [15:0]         last_sw_r;
  logic [15:0]         cmd_cnt_r;
  logic                rsp_valid_r;
  ptc_pkg::ptc_rsp_s   rsp_r;

  // APB decode
  wire apb_acc   = psel & penable;
  wire apb_wr    = apb_acc & pwrite;
  wire sel_afi   = (paddr == ptc_pkg::OFS_AFI);
  wire sel_ro    = (paddr == ptc_pkg::OFS_RO_LIM);
  wire sel_enc   = (paddr == ptc_pkg::OFS_ENC_LO);
  wire sel_stat  = (paddr == ptc_pkg::OFS_STATUS);
  wire sel_cnt   = (paddr == ptc_pkg::OFS_COUNT);
  wire sel_any   = sel_afi | sel_ro | sel_enc | sel_stat | sel_cnt;

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~sel_any;

  // Read mux, zero for unmapped
  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_afi) begin
      prdata = {24'h00_0000, afi_r};
    end else if (sel_ro) begin
      prdata = {19'h0_0000, ro_lim_r};
    end else if (sel_enc) begin
      prdata = {19'h0_0000, enc_lo_r};
    end else if (sel_stat) begin
      prdata = {4'h0, last_sw_r, 8'h00, 4'(state_r)};
    end else if (sel_cnt) begin
      prdata = {16'h0000, cmd_cnt_r};
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afi_r    <= ptc_pkg::AFI_RST;
      ro_lim_r <= ptc_pkg::RO_LIM_RST;
      enc_lo_r <= ptc_pkg::ENC_LO_RST;
    end else if (apb_wr) begin
      if (sel_afi) begin
        afi_r <= pwdata[7:0];
      end else if (sel_ro) begin
        ro_lim_r <= pwdata[12:0];
      end else if (sel_enc) begin
        enc_lo_r <= pwdata[12:0];
      end
    end
  end

  // Command port never stalls; one command per cycle
  assign cmd_ready = 1'b1;
  wire take = cmd_valid;

  // Link command decode
  wire is_link  = (cmd.blk == ptc_pkg::PTC_BLK_LINK);
  wire is_req   = is_link && (cmd.code == ptc_pkg::LINK_REQ_WAKE);
  wire is_att   = is_link && (cmd.code == ptc_pkg::LINK_ATTRIB);
  wire is_hlt   = is_link && (cmd.code == ptc_pkg::LINK_HALT);
  // Only bit 3 is looked at; 7-5 and slot code 2-0 are ignored
  wire wake     = cmd.param[ptc_pkg::PRM_WAKE_BIT];
  wire in_idle  = (state_r == ptc_pkg::PTC_ST_IDLE);
  wire in_halt  = (state_r == ptc_pkg::PTC_ST_HALT);
  wire in_ready = (state_r == ptc_pkg::PTC_ST_READY);
  wire in_act   = (state_r == ptc_pkg::PTC_ST_ACTIVE);
  wire req_ok   = wake ? (in_idle | in_halt) : in_idle;
  wire afi_ok   = afi_match(cmd.afi, afi_r);
  wire ans_req  = is_req && req_ok && afi_ok;

  // APDU field decode
  wire [2:0]  mode     = cmd.p1[ptc_pkg::P1_MODE_LSB +: 3];
  wire        enc      = (mode == ptc_pkg::MODE_PRIV) || (mode == ptc_pkg::MODE_FAM);
  wire        mode_bad = (mode != ptc_pkg::MODE_PLAIN) && !enc;
  wire [12:0] addr     = {1'b0, cmd.p1[3:0], cmd.p2};
  wire        ins_sel  = (cmd.ins == ptc_pkg::INS_SELECT);
  wire        ins_rd   = (cmd.ins == ptc_pkg::INS_READ);
  wire        ins_wr   = (cmd.ins == ptc_pkg::INS_WRITE);
  wire [8:0]  xfer_len = ins_wr ? cmd.lc : cmd.le;
  wire [12:0] xfer_end = addr + 13'(xfer_len);

  // Parameter checks
  wire p1_bad   = cmd.p1[ptc_pkg::P1_ERR_BIT];
  wire adr_bad  = (addr >= NVM_LIM) || (xfer_end > NVM_LIM);
  wire aln_bad  = enc && (addr[ptc_pkg::ENC_UNIT_LSB-1:0] != '0);
  wire p12_bad  = p1_bad || mode_bad || adr_bad || aln_bad;
  wire lng_bad  = len_bad(xfer_len, enc);
  wire ro_hit   = ins_wr && (addr < ro_lim_r);
  wire enc_hit  = !enc && (xfer_end > enc_lo_r);

  // Status word selection in priority order
  logic [15:0] apdu_sw;
  always_comb begin
    apdu_sw = ptc_pkg::SW_OK;
    if (cmd.cla != ptc_pkg::CLA_OK) begin
      apdu_sw = ptc_pkg::SW_CLA_ERR;
    end else if (!(ins_sel || ins_rd || ins_wr)) begin
      apdu_sw = ptc_pkg::SW_INS_ERR;
    end else if (ins_sel) begin
      // No file system; bad P1 with no data field reads as length error
      if (p1_bad && (cmd.lc == 9'h000)) begin
        apdu_sw = ptc_pkg::SW_LEN_ERR;
      end else if (p1_bad) begin
        apdu_sw = ptc_pkg::SW_P12_ERR;
      end
    end else if (p1_bad || mode_bad || adr_bad) begin
      apdu_sw = ptc_pkg::SW_P12_ERR;
    end else if (aln_bad) begin
      apdu_sw = ptc_pkg::SW_P12_ERR;
    end else if (lng_bad) begin
      apdu_sw = ptc_pkg::SW_LEN_ERR;
    end else if (ro_hit) begin
      apdu_sw = ptc_pkg::SW_ACC_ERR;
    end else if (enc_hit) begin
      apdu_sw = ptc_pkg::SW_ACC_ERR;
    end
  end

  // Answer and next state
  logic              ans;
  ptc_pkg::ptc_rsp_s ans_d;
  always_comb begin
    state_nxt  = state_r;
    ans        = 1'b0;
    ans_d.kind = ptc_pkg::PTC_RSP_APDU;
    ans_d.sw   = ptc_pkg::SW_OK;
    if (take) begin
      case (state_r)
        ptc_pkg::PTC_ST_IDLE, ptc_pkg::PTC_ST_HALT: begin
          if (ans_req) begin
            state_nxt  = ptc_pkg::PTC_ST_READY;
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_ATQB;
          end
        end
        ptc_pkg::PTC_ST_READY: begin
          if (is_att) begin
            state_nxt  = ptc_pkg::PTC_ST_ACTIVE;
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_ATTRIB;
          end else if (is_hlt) begin
            state_nxt  = ptc_pkg::PTC_ST_HALT;
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_APDU;
          end else if (is_req && afi_ok) begin
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_ATQB;
          end
        end
        ptc_pkg::PTC_ST_ACTIVE: begin
          if (cmd.blk == ptc_pkg::PTC_BLK_IBLK) begin
            ans = 1'b1;
            if (cmd.chain) begin
              ans_d.kind = ptc_pkg::PTC_RSP_ACK;
            end else begin
              ans_d.sw = apdu_sw;
            end
          end else if (cmd.blk == ptc_pkg::PTC_BLK_ACK || cmd.blk == ptc_pkg::PTC_BLK_NAK) begin
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_ACK;
          end else if (cmd.blk == ptc_pkg::PTC_BLK_DESEL) begin
            state_nxt  = ptc_pkg::PTC_ST_HALT;
            ans        = 1'b1;
            ans_d.kind = ptc_pkg::PTC_RSP_DESEL;
          end else if (is_hlt) begin
            state_nxt  = ptc_pkg::PTC_ST_HALT;
            ans        = 1'b1;
          end
        end
        default: begin
          state_nxt = ptc_pkg::PTC_ST_IDLE;
        end
      endcase
    end
  end

  // Protocol state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ptc_pkg::PTC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= ans;
      if (ans) begin
        rsp_r <= ans_d;
      end
    end
  end

  // Status history for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sw_r <= 16'h0000;
      cmd_cnt_r <= 16'h0000;
    end else if (ans && ans_d.kind == ptc_pkg::PTC_RSP_APDU && in_act) begin
      last_sw_r <= ans_d.sw;
      cmd_cnt_r <= cmd_cnt_r + 16'h0001;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp       = rsp_r;

endmodule // ptc_core

// ### testbench/ptc_reader.sv
`timescale 1ns/10ps
// Reader model: one command block per call, answer looked at a cycle later
module ptc_reader (
  input  wire logic              pclk,
  input  wire logic              rsp_valid,
  input  wire ptc_pkg::ptc_rsp_s rsp,
  output logic                   cmd_valid,
  output ptc_pkg::ptc_cmd_s      cmd
);
  // Quiet bus at start
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One-cycle block, fields scrambled once released
  task xfer(input ptc_pkg::ptc_cmd_s c, output logic got, output ptc_pkg::ptc_rsp_s rr);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd <= ~c;
    // Answer stands for the cycle after the take edge; sample at its closing edge
    @(posedge pclk);
    got = rsp_valid;
    rr = rsp;
  endtask
endmodule // ptc_reader

// ### testbench/ptc_core_asserts.sv
`timescale 1ns/10ps
// Answer checks at the command ports
module ptc_chk #(
  parameter int MAX_LEN = 256
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              cmd_valid,
  input wire ptc_pkg::ptc_cmd_s cmd,
  input wire logic              rsp_valid,
  input wire ptc_pkg::ptc_rsp_s rsp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command classes and answer fields
  wire        lk = cmd_valid && cmd.blk == ptc_pkg::PTC_BLK_LINK;
  wire        ix = cmd_valid && cmd.blk == ptc_pkg::PTC_BLK_IBLK && !cmd.chain;
  wire        ib = ix && cmd.cla == 8'h00;
  wire        nr = !rsp_valid;
  wire [2:0]  k  = rsp.kind;
  wire [15:0] s  = rsp.sw;
  // Answers tied to their commands
  property p_ans; rsp_valid |-> $past(cmd_valid); endproperty
  a_ans: assert property (p_ans) else $error("answer without command");
  property p_req; lk && cmd.code == 8'h05 |=> nr || k == 3'h0; endproperty
  a_req: assert property (p_req) else $error("request answer kind");
  property p_att; lk && cmd.code == 8'h1d |=> nr || k == 3'h1; endproperty
  a_att: assert property (p_att) else $error("attrib answer kind");
  property p_hlt; lk && cmd.code == 8'h50 |=> nr || {k, s} == 19'h29000; endproperty
  a_hlt: assert property (p_hlt) else $error("halt answer");
  property p_cla; ix && cmd.cla != 8'h00 |=> nr || s == 16'h6e00; endproperty
  a_cla: assert property (p_cla) else $error("class status");
  property p_ins; ib && !(cmd.ins inside {8'ha4, 8'hb0, 8'hd6}) |=> nr || s == 16'h6d00; endproperty
  a_ins: assert property (p_ins) else $error("instruction status");
  property p_p1; ib && cmd.ins == 8'hb0 && cmd.p1[7] |=> nr || s == 16'h6a86; endproperty
  a_p1: assert property (p_p1) else $error("parameter status");
  property p_len; ib && cmd.ins == 8'hb0 && cmd.p1 == 8'h00 && (cmd.le == 9'h0 || cmd.le > MAX_LEN)
    |=> nr || s == 16'h6700; endproperty
  a_len: assert property (p_len) else $error("length status");
  property p_sel; ib && cmd.ins == 8'ha4 && !cmd.p1[7] && cmd.le inside {[1:MAX_LEN]} |=> nr || s == 16'h9000;
  endproperty
  a_sel: assert property (p_sel) else $error("select status");
  property p_rbk; cmd_valid && cmd.blk inside {ptc_pkg::PTC_BLK_ACK, ptc_pkg::PTC_BLK_NAK} |=> nr || k == 3'h3;
  endproperty
  a_rbk: assert property (p_rbk) else $error("reply block answer");
endmodule // ptc_chk

bind ptc_core ptc_chk #(.MAX_LEN(MAX_LEN)) u_chk (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp));

// ### testbench/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the command block
module testbench;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_valid, rsp_valid, g, e;
  logic              cmd_ready;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  ptc_pkg::ptc_cmd_s cmd;
  ptc_pkg::ptc_rsp_s rsp, r;
  int                fails, samples_checked;
  // Family values, bit 8 set where an answer is due
  logic [8:0]        at [7] = '{9'h100, 9'h130, 9'h105, 9'h135, 9'h036, 9'h053, 9'h040};

  ptc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp));
  ptc_reader rd (.pclk(pclk), .rsp_valid(rsp_valid), .rsp(rsp), .cmd_valid(cmd_valid), .cmd(cmd));

  // Clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task ck(input logic [31:0] a, b);
    samples_checked++;
    if (a !== b) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, a, b);
    end
  endtask
  // APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    ck({31'h0, e}, 32'h0);
  endtask
  task rg(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    ck(q & m, x);
    ck({31'h0, e}, 32'h0);
  endtask
  function automatic ptc_pkg::ptc_cmd_s lnk(input logic [7:0] c, a, p);
    return {3'h0, 1'b0, c, a, p, 50'h0};
  endfunction
  function automatic ptc_pkg::ptc_cmd_s api(input logic [7:0] cl, i, p1, p2, input logic [8:0] lc, le);
    return {ptc_pkg::PTC_BLK_IBLK, 1'b0, 24'h0, cl, i, p1, p2, lc, le};
  endfunction
  // Send a block, compare presence and kind, and status when an APDU answer is due
  task go(input ptc_pkg::ptc_cmd_s c, input logic [3:0] x, input logic [15:0] s = 16'h0);
    rd.xfer(c, g, r);
    ck({31'h0, cmd_ready}, 32'h1);
    ck({28'h0, g, g ? r.kind : 3'h0}, {28'h0, x});
    if (x == 4'ha) ck({16'h0, r.sw}, {16'h0, s});
  endtask
  task ap(input logic [7:0] cl, i, p1, p2, input logic [8:0] lc, le, input logic [15:0] s);
    go(api(cl, i, p1, p2, lc, le), 4'ha, s);
  endtask

  task t_regs;
    rg(12'h000, 32'h0);
    rg(12'h004, 32'h0);
    rg(12'h008, 32'h1000);
    wr(12'h00c, 32'hffffffff);
    rg(12'h00c, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    ck({q[30:0], e}, 32'h1);
  endtask
  task t_link;
    go(lnk(8'h05, 8'h00, 8'he7), 4'h8);
    rg(12'h00c, 32'h2, 32'hf);
    go(lnk(8'h50, 8'h00, 8'h00), 4'ha, 16'h9000);
    rg(12'h00c, 32'h8, 32'hf);
    go(lnk(8'h05, 8'h00, 8'h07), 4'h0);
    go(api(8'h00, 8'hb0, 8'h00, 8'h00, 9'h0, 9'h10), 4'h0);
    go(lnk(8'h05, 8'h00, 8'hef), 4'h8);
    go(lnk(8'h1d, 8'h00, 8'h00), 4'h9);
    rg(12'h00c, 32'h4, 32'hf);
  endtask
  task t_apdu;
    wr(12'h004, 32'h100);
    wr(12'h008, 32'h800);
    ap(8'h01, 8'hb0, 8'h00, 8'h00, 9'h0, 9'h10, 16'h6e00);
    ap(8'h00, 8'h12, 8'h00, 8'h00, 9'h0, 9'h10, 16'h6d00);
    ap(8'h00, 8'hb0, 8'h80, 8'h00, 9'h0, 9'h10, 16'h6a86);
    ap(8'h00, 8'hb0, 8'h40, 8'h00, 9'h0, 9'h10, 16'h6a86);
    ap(8'h00, 8'hb0, 8'h0f, 8'hf8, 9'h0, 9'h10, 16'h6a86);
    ap(8'h00, 8'hb0, 8'h20, 8'h08, 9'h0, 9'h10, 16'h6a86);
    ap(8'h00, 8'hb0, 8'h20, 8'h00, 9'h0, 9'h14, 16'h6700);
    ap(8'h00, 8'hb0, 8'h00, 8'h00, 9'h0, 9'h0, 16'h6700);
    ap(8'h00, 8'hb0, 8'h00, 8'h00, 9'h0, 9'h101, 16'h6700);
    ap(8'h00, 8'hb0, 8'h00, 8'h00, 9'h0, 9'h10, 16'h9000);
    ap(8'h00, 8'hd6, 8'h00, 8'h80, 9'h10, 9'h0, 16'h6f00);
    ap(8'h00, 8'hd6, 8'h02, 8'h00, 9'h10, 9'h0, 16'h9000);
    ap(8'h00, 8'hb0, 8'h07, 8'hf8, 9'h0, 9'h10, 16'h6f00);
    ap(8'h00, 8'hb0, 8'h28, 8'h00, 9'h0, 9'h10, 16'h9000);
    ap(8'h00, 8'hb0, 8'h30, 8'h10, 9'h0, 9'h20, 16'h9000);
    ap(8'h00, 8'ha4, 8'h00, 8'h00, 9'h0, 9'h10, 16'h9000);
    ap(8'h00, 8'ha4, 8'h80, 8'h00, 9'h0, 9'h10, 16'h6700);
    ap(8'h00, 8'ha4, 8'h80, 8'h00, 9'h1, 9'h10, 16'h6a86);
    rg(12'h010, 32'h12);
    rg(12'h00c, 32'h06a86004);
    go({ptc_pkg::PTC_BLK_IBLK, 1'b1, 74'h0}, 4'hb);
    go({ptc_pkg::PTC_BLK_NAK, 75'h0}, 4'hb);
    go({ptc_pkg::PTC_BLK_ACK, 75'h0}, 4'hb);
    go({ptc_pkg::PTC_BLK_DESEL, 75'h0}, 4'hc);
    rg(12'h00c, 32'h8, 32'hf);
  endtask
  task t_afi;
    wr(12'h000, 32'h35);
    foreach (at[i]) begin
      go(lnk(8'h05, at[i][7:0], 8'h08), at[i][8] ? 4'h8 : 4'h0);
      if (at[i][8]) go(lnk(8'h50, 8'h00, 8'h00), 4'ha, 16'h9000);
    end
  endtask

  task final_report;
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_link();
    t_apdu();
    t_afi();
    final_report();
  end
  // Watchdog
  initial begin
    #50000;
    fails++;
    final_report();
  end
endmodule // testbench
